// *** verification/spfl_link_monitor.sv ***
// concurrent checks on the serial link and the device status outputs
`timescale 1ns/1ps
module spfl_link_monitor #(
  parameter int BUSY_CYCLES = 300
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic busyOut,
  input wire logic welOut,
  input wire logic memWrEn,
  input wire logic eraseReq,
  input wire logic cmdRefused
);
  logic [31:0] busyCnt;

  // counts the busy run so its length can be judged where it ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt <= 32'h0;
    end else begin
      busyCnt <= busyOut ? busyCnt + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_busy_start; !busyOut ##1 busyOut; endsequence
  sequence s_busy_end;   busyOut ##1 !busyOut; endsequence

  property p_busy_len;     s_busy_end |-> busyCnt == BUSY_CYCLES; endproperty
  property p_wel_clear;    s_busy_end |-> !welOut; endproperty
  property p_wel_needed;   s_busy_start |-> $past(welOut); endproperty
  property p_erase_starts; eraseReq |-> $rose(busyOut); endproperty
  property p_refuse_idle;  cmdRefused |-> !busyOut; endproperty
  property p_busy_ignores; busyOut && !$rose(busyOut) |-> !eraseReq && !cmdRefused; endproperty
  property p_wr_in_busy;   memWrEn |-> busyOut; endproperty
  property p_sck_idle;     csN |-> !sck; endproperty
  property p_cs_frame;     $fell(csN) |-> !csN [*8]; endproperty
  property p_mosi_hold;    sck && $past(sck) |-> $stable(mosi); endproperty
  // sync delay puts miso changes inside the low half of sck
  property p_miso_fall;    !csN && $changed(miso) |-> !sck; endproperty

  a_busy_len: assert property (p_busy_len) else $error("busy length off");
  a_wel_clear: assert property (p_wel_clear) else $error("latch kept at end");
  a_wel_needed: assert property (p_wel_needed) else $error("cycle without latch");
  a_erase_starts: assert property (p_erase_starts) else $error("erase without busy");
  a_refuse_idle: assert property (p_refuse_idle) else $error("refusal while busy");
  a_busy_ignores: assert property (p_busy_ignores) else $error("command while busy");
  a_wr_in_busy: assert property (p_wr_in_busy) else $error("write outside cycle");
  a_sck_idle: assert property (p_sck_idle) else $error("clock not idle low");
  a_cs_frame: assert property (p_cs_frame) else $error("select frame too short");
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved in high");
  a_miso_fall: assert property (p_miso_fall) else $error("output moved in high");
endmodule

// *** verification/spi_flash_program_erase_cmds_tb_top.sv ***
// testbench: apb driven host joined to the flash device end
`timescale 1ns/1ps
module spi_flash_program_erase_cmds_tb_top
  import spfl_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, numErrors, totalChecks, refCnt, erCnt, wrCnt, w0;
  logic        lastErr;
  logic protComp, protSec, protTop;
  logic [2:0]  protRange;
  logic busyOut, welOut, memWrEn, eraseReq, cmdRefused;
  logic [23:0] memWrAddr, eraseAddr;
  logic [7:0]  memWrData;
  logic [7:0]  pg [256];
  spfl_erase_t eraseKind;
  logic [7:0]  eOp [4] = '{8'h20, 8'hD8, 8'hC7, 8'h60};
  logic [1:0]  eKind [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
  logic [23:0] eBase [4] = '{24'h123000, 24'h120000, 24'h000000, 24'h000000};
  spfl_link_if lnk();
  spfl_host #(.SCK_HALF(4)) u_spfl_host (.clk(clk), .rst_n(rst_n), .link(lnk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // short cycle counts keep the run brief; 300 still exceeds a page
  spfl_device #(.PROG_CYCLES(300), .SE_CYCLES(300), .BE_CYCLES(300), .CE_CYCLES(300))
    u_spfl_device (.clk(clk), .rst_n(rst_n), .link(lnk), .protectComplement(protComp),
    .protectSectorGranularity(protSec), .protectTopBottom(protTop),
    .protectRangeBit2(protRange[2]), .protectRangeBit1(protRange[1]),
    .protectRangeBit0(protRange[0]), .busyOut(busyOut), .welOut(welOut), .memWrEn(memWrEn),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .eraseReq(eraseReq), .eraseKind(eraseKind),
    .eraseAddr(eraseAddr), .cmdRefused(cmdRefused));
  spfl_link_monitor #(.BUSY_CYCLES(300)) u_spfl_link_monitor (.clk(clk), .rst_n(rst_n),
    .sck(lnk.sck), .csN(lnk.csN), .mosi(lnk.mosi), .miso(lnk.miso), .busyOut(busyOut),
    .welOut(welOut), .memWrEn(memWrEn), .eraseReq(eraseReq), .cmdRefused(cmdRefused));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (memWrEn === 1'b1) begin
      wrCnt <= wrCnt + 32'h1;
      pg[memWrAddr[7:0]] <= memWrData;
    end
    if (eraseReq === 1'b1) erCnt <= erCnt + 32'h1;
    if (cmdRefused === 1'b1) refCnt <= refCnt + 32'h1;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks = totalChecks + 32'h1;
    if (got !== exp) begin
      numErrors = numErrors + 32'h1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task closeOut();
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 32'h0 && totalChecks > 32'h0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // one frame: address, data word, command (a repeat mid-frame must be refused), then poll
  task frame(input logic [7:0] op, input logic ae, input logic [23:0] a, input logic [8:0] n,
             input logic [2:0] x, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, 8'h04, {8'h00, a}, r);
    apb(1'b1, 8'h08, d, r);
    apb(1'b1, 8'h00, {11'h000, x, n, ae, op}, r);
    chk(32'(lastErr), 32'h0);
    apb(1'b1, 8'h00, {11'h000, x, n, ae, op}, r);
    chk(32'(lastErr), 32'h1);
    do begin
      apb(1'b0, 8'h0C, 32'h0, r);
    end while (r[0] !== 1'b0);
    repeat (8) @(posedge clk);
  endtask

  task run(input logic [7:0] op, input logic ae, input logic [23:0] a, input logic [8:0] n,
           input logic [2:0] x, input logic [31:0] d, input logic [31:0] eRef,
           input logic [31:0] eEr);
    logic [31:0] r0, e0;
    r0 = refCnt;
    e0 = erCnt;
    frame(op, ae, a, n, x, d);
    chk(refCnt - r0, eRef);
    chk(erCnt - e0, eEr);
  endtask

  // the watchdog bounds this wait
  task idle();
    while (busyOut !== 1'b0) @(posedge clk);
  endtask

  initial begin
    rst_n <= 1'b0;
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    {protComp, protSec, protTop, protRange} <= '0;
    {numErrors, totalChecks, refCnt, erCnt, wrCnt} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run(8'h02, 1'b1, 24'h000010, 9'h001, 3'h0, 32'h000000A5, 32'h1, 32'h0);
    run(8'h06, 1'b0, 24'h0, 9'h000, 3'h0, 32'h0, 32'h0, 32'h0);
    chk(32'(welOut), 32'h1);
    run(8'h02, 1'b1, 24'h000010, 9'h001, 3'h3, 32'h000000A5, 32'h1, 32'h0);
    run(8'h02, 1'b1, 24'h0000FE, 9'h003, 3'h0, 32'h00332211, 32'h0, 32'h0);
    chk(32'(busyOut), 32'h1);
    run(8'hC7, 1'b0, 24'h0, 9'h000, 3'h0, 32'h0, 32'h0, 32'h0);
    frame(8'h05, 1'b0, 24'h0, 9'h001, 3'h0, 32'h0);
    apb(1'b0, 8'h0C, 32'h0, rd);
    chk(32'(rd[15:8]), 32'h03);
    idle();
    chk(32'(welOut), 32'h0);
    chk(wrCnt, 32'h3);
    chk(32'(pg[8'hFE]), 32'h11);
    chk(32'(pg[8'hFF]), 32'h22);
    chk(32'(pg[8'h00]), 32'h33);
    for (int i = 0; i < 4; i++) begin
      run(8'h06, 1'b0, 24'h0, 9'h000, 3'h0, 32'h0, 32'h0, 32'h0);
      run(eOp[i], eKind[i] != 2'h2, 24'h123456, 9'h000, 3'h0, 32'h0, 32'h0, 32'h1);
      chk(32'(eraseKind), 32'(eKind[i]));
      chk(32'(eraseAddr), 32'(eBase[i]));
      idle();
      chk(32'(welOut), 32'h0);
    end
    run(8'h06, 1'b0, 24'h0, 9'h000, 3'h0, 32'h0, 32'h0, 32'h0);
    run(8'hC7, 1'b0, 24'h0, 9'h000, 3'h2, 32'h0, 32'h1, 32'h0);
    protRange <= 3'h1;
    run(8'h02, 1'b1, 24'hFF0000, 9'h001, 3'h0, 32'h000000A5, 32'h1, 32'h0);
    run(8'hC7, 1'b0, 24'h0, 9'h000, 3'h0, 32'h0, 32'h1, 32'h0);
    run(8'hD8, 1'b1, 24'hFF0000, 9'h000, 3'h0, 32'h0, 32'h1, 32'h0);
    run(8'h20, 1'b1, 24'h000000, 9'h000, 3'h0, 32'h0, 32'h0, 32'h1);
    idle();
    run(8'h06, 1'b0, 24'h0, 9'h000, 3'h0, 32'h0, 32'h0, 32'h0);
    w0 = wrCnt;
    run(8'h02, 1'b1, 24'h000101, 9'h101, 3'h0, 32'h44332211, 32'h0, 32'h0);
    idle();
    chk(wrCnt - w0, 32'h100);
    chk(32'(pg[8'h00]), 32'h44);
    chk(32'(memWrAddr), 32'h00000100);
    // bottom span protects sector 0, then the complement frees it again
    protTop <= 1'b1;
    run(8'h06, 1'b0, 24'h0, 9'h000, 3'h0, 32'h0, 32'h0, 32'h0);
    run(8'h20, 1'b1, 24'h000000, 9'h000, 3'h0, 32'h0, 32'h1, 32'h0);
    protComp <= 1'b1;
    run(8'h20, 1'b1, 24'h000000, 9'h000, 3'h0, 32'h0, 32'h0, 32'h1);
    idle();
    closeOut();
  end

  initial begin
    repeat (90000) @(posedge clk);
    numErrors = numErrors + 32'h1;
    closeOut();
  end
endmodule

// *** verilog/spfl_device.sv ***
// flash device end: command decode, page buffer and self-timed cycles
`timescale 1ns/1ps
`include "spfl_regs.svh"
module spfl_device
  import spfl_pkg::*;
#(
  parameter int unsigned PAGE_BYTES = `SPFL_PAGE_BYTES,
  parameter int unsigned PROG_CYCLES = (`SPFL_PROG_TIME_NS + `SPFL_CLK_NS - 1) / `SPFL_CLK_NS,
  parameter int unsigned SE_CYCLES   = (`SPFL_SE_TIME_NS + `SPFL_CLK_NS - 1) / `SPFL_CLK_NS,
  parameter int unsigned BE_CYCLES   = (`SPFL_BE_TIME_NS + `SPFL_CLK_NS - 1) / `SPFL_CLK_NS,
  parameter int unsigned CE_CYCLES   = (`SPFL_CE_TIME_NS + `SPFL_CLK_NS - 1) / `SPFL_CLK_NS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  spfl_link_if.device      link,
  input  wire logic        protectComplement,
  input  wire logic        protectSectorGranularity,
  input  wire logic        protectTopBottom,
  input  wire logic        protectRangeBit2,
  input  wire logic        protectRangeBit1,
  input  wire logic        protectRangeBit0,
  output logic             busyOut,
  output logic             welOut,
  output logic             memWrEn,
  output logic [23:0]      memWrAddr,
  output logic [7:0]       memWrData,
  output logic             eraseReq,
  output spfl_erase_t      eraseKind,
  output logic [23:0]      eraseAddr,
  output logic             cmdRefused
);
  localparam int IDX_W = $clog2(PAGE_BYTES);

  logic [2:0]            sckSync;
  logic [2:0]            csSync;
  logic [1:0]            mosiSync;
  logic [2:0]            bitCnt;
  logic [2:0]            byteCnt;
  logic [6:0]            rxShift;
  logic [7:0]            opcodeReg;
  logic [23:0]           addrReg;
  logic [7:0]            txShift;
  logic                  misoReg;
  logic [7:0]            pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageValid;
  logic [IDX_W-1:0]      writeIdx;
  logic [IDX_W:0]        walkIdx;
  logic [23-IDX_W:0]     pageBase;
  logic [31:0]           cycleCnt;
  spfl_dev_state_t       stateReg;
  logic                  busyReg;
  logic                  welReg;
  logic [5:0]            protBits;
  logic [7:0]            statusByte;
  logic                  okCmd;
  logic                  startProg;
  logic                  startSe;
  logic                  startBe;
  logic                  startCe;
  logic                  isPe;

  // region is contiguous at one end, so checking both ends of a span covers it
  function automatic logic protHit(input logic [23:0] a, input logic [5:0] pb);
    logic [24:0] span;
    logic        hit;
    span = 25'h0000000;
    hit  = 1'b0;
    if (pb[2:0] != 3'h0) begin
      span = 25'h0000001 << ((pb[4] ? 5'h0B : 5'h0F) + {2'h0, pb[2:0]});
      hit  = pb[3] ? ({1'b0, a} < span) : ({1'b0, a} >= (`SPFL_MEM_TOP - span));
    end
    return hit ^ pb[5];
  endfunction

  wire logic sckRise  = sckSync[1] & ~sckSync[2];
  wire logic sckFall  = ~sckSync[1] & sckSync[2];
  wire logic csLow    = ~csSync[1];
  wire logic csFall   = ~csSync[1] & csSync[2];
  wire logic csRise   = csSync[1] & ~csSync[2];
  wire logic [7:0] rxByte = {rxShift, mosiSync[1]};
  wire logic byteDone = sckRise & csLow & (bitCnt == 3'h7);
  wire logic bufWr    = byteDone & (byteCnt >= 3'h4) & (opcodeReg == OP_PROG) & ~busyReg;
  wire logic cycleDone = busyReg & (cycleCnt == 32'h0);

  assign link.miso = misoReg;
  assign busyOut   = busyReg;
  assign welOut    = welReg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckSync  <= 3'h0;
      csSync   <= 3'h7;
      mosiSync <= 2'h0;
    end else begin
      sckSync  <= {sckSync[1:0], link.sck};
      csSync   <= {csSync[1:0], link.csN};
      mosiSync <= {mosiSync[0], link.mosi};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt  <= 3'h0;
      byteCnt <= 3'h0;
      rxShift <= 7'h00;
    end else if (csFall) begin
      bitCnt  <= 3'h0;
      byteCnt <= 3'h0;
    end else if (sckRise && csLow) begin
      bitCnt  <= bitCnt + 3'h1;
      rxShift <= rxByte[6:0];
      if (bitCnt == 3'h7 && byteCnt != 3'h7) begin
        byteCnt <= byteCnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opcodeReg <= 8'h00;
      addrReg   <= 24'h000000;
    end else if (byteDone) begin
      if (byteCnt == 3'h0) begin
        opcodeReg <= rxByte;
      end else if (byteCnt <= 3'h3) begin
        addrReg <= {addrReg[15:0], rxByte};
      end
    end
  end

  // buffer frozen while busy so the running cycle keeps its data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeIdx  <= '0;
      pageValid <= '0;
    end else begin
      if (byteDone && byteCnt == 3'h0 && rxByte == OP_PROG && !busyReg) begin
        pageValid <= '0;
      end else if (bufWr) begin
        pageValid[writeIdx] <= 1'b1;
      end
      if (byteDone && byteCnt == 3'h3) begin
        writeIdx <= rxByte[IDX_W-1:0];
      end else if (bufWr) begin
        writeIdx <= writeIdx + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (bufWr) begin
      pageBuf[writeIdx] <= rxByte;
    end
  end

  always_comb begin
    statusByte = 8'h00;
    statusByte[`SPFL_SR_BUSY_BIT] = busyReg;
    statusByte[`SPFL_SR_WEL_BIT]  = welReg;
    statusByte[`SPFL_SR_BP_LSB +: 3] = {protectRangeBit2, protectRangeBit1, protectRangeBit0};
    statusByte[`SPFL_SR_TB_BIT]   = protectTopBottom;
    statusByte[`SPFL_SR_SEC_BIT]  = protectSectorGranularity;
  end

  // status is reloaded at every byte end of an RDSR frame, no busy gating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift <= 8'h00;
      misoReg <= 1'b0;
    end else if (csRise) begin
      txShift <= 8'h00;
      misoReg <= 1'b0;
    end else if (byteDone && ((byteCnt == 3'h0 && rxByte == OP_RDSR) ||
                              (byteCnt != 3'h0 && opcodeReg == OP_RDSR))) begin
      txShift <= statusByte;
    end else if (sckFall && csLow) begin
      misoReg <= txShift[7];
      txShift <= {txShift[6:0], 1'b0};
    end
  end

  always_comb begin
    protBits  = {protectComplement, protectSectorGranularity, protectTopBottom,
                 protectRangeBit2, protectRangeBit1, protectRangeBit0};
    okCmd     = csRise && bitCnt == 3'h0 && !busyReg;
    isPe      = byteCnt != 3'h0 &&
                opcodeReg inside {OP_PROG, OP_SE, OP_BE, OP_CE1, OP_CE2};
    startProg = okCmd && welReg && opcodeReg == OP_PROG && byteCnt >= 3'h5 &&
                !protHit({addrReg[23:IDX_W], {IDX_W{1'b0}}}, protBits);
    startSe   = okCmd && welReg && opcodeReg == OP_SE && byteCnt == 3'h4 &&
                !protHit({addrReg[23:12], 12'h000}, protBits) &&
                !protHit({addrReg[23:12], 12'hFFF}, protBits);
    startBe   = okCmd && welReg && opcodeReg == OP_BE && byteCnt == 3'h4 &&
                !protHit({addrReg[23:16], 16'h0000}, protBits) &&
                !protHit({addrReg[23:16], 16'hFFFF}, protBits);
    startCe   = okCmd && welReg && byteCnt == 3'h1 &&
                (opcodeReg == OP_CE1 || opcodeReg == OP_CE2) &&
                !protHit(24'h000000, protBits) && !protHit(24'hFFFFFF, protBits);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      welReg <= 1'b0;
    end else if (cycleDone) begin
      welReg <= 1'b0;
    end else if (okCmd && byteCnt == 3'h1 && opcodeReg == OP_WREN) begin
      welReg <= 1'b1;
    end else if (okCmd && byteCnt == 3'h1 && opcodeReg == OP_WRDI) begin
      welReg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ST_IDLE;
      busyReg  <= 1'b0;
      cycleCnt <= 32'h0;
      walkIdx  <= '0;
      pageBase <= '0;
    end else begin
      unique case (stateReg)
        ST_IDLE: begin
          if (startProg) begin
            stateReg <= ST_PROG;
            busyReg  <= 1'b1;
            cycleCnt <= PROG_CYCLES - 1;
            walkIdx  <= '0;
            pageBase <= addrReg[23:IDX_W];
          end else if (startSe || startBe || startCe) begin
            stateReg <= ST_ERASE;
            busyReg  <= 1'b1;
            cycleCnt <= startSe ? SE_CYCLES - 1 : (startBe ? BE_CYCLES - 1 : CE_CYCLES - 1);
          end
        end
        ST_PROG, ST_ERASE: begin
          if (!walkIdx[IDX_W]) begin
            walkIdx <= walkIdx + 1'b1;
          end
          if (cycleCnt == 32'h0) begin
            stateReg <= ST_IDLE;
            busyReg  <= 1'b0;
          end else begin
            cycleCnt <= cycleCnt - 32'h1;
          end
        end
      endcase
    end
  end

  // page walk needs PROG_CYCLES above PAGE_BYTES
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memWrEn    <= 1'b0;
      memWrAddr  <= 24'h000000;
      memWrData  <= 8'h00;
      eraseReq   <= 1'b0;
      eraseKind  <= ER_SECTOR;
      eraseAddr  <= 24'h000000;
      cmdRefused <= 1'b0;
    end else begin
      memWrEn    <= stateReg == ST_PROG && !walkIdx[IDX_W] && pageValid[walkIdx[IDX_W-1:0]];
      memWrAddr  <= {pageBase, walkIdx[IDX_W-1:0]};
      memWrData  <= pageBuf[walkIdx[IDX_W-1:0]];
      eraseReq   <= startSe || startBe || startCe;
      // a program or erase frame that lands while busy is dropped silently, not flagged
      cmdRefused <= csRise && isPe && !busyReg &&
                    !(startProg || startSe || startBe || startCe);
      if (startSe) begin
        eraseKind <= ER_SECTOR;
        eraseAddr <= {addrReg[23:12], 12'h000};
      end else if (startBe) begin
        eraseKind <= ER_BLOCK;
        eraseAddr <= {addrReg[23:16], 16'h0000};
      end else if (startCe) begin
        eraseKind <= ER_CHIP;
        eraseAddr <= 24'h000000;
      end
    end
  end
endmodule

// *** verilog/spfl_host.sv ***
// host controller end: apb registers and serial frame generator
`timescale 1ns/1ps
`include "spfl_regs.svh"
module spfl_host
  import spfl_pkg::*;
#(
  parameter int unsigned SCK_HALF = `SPFL_SCK_HALF
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  spfl_link_if.host        link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  logic [7:0]       opReg;
  logic             hasAddrReg;
  logic [8:0]       countReg;
  logic [2:0]       extraReg;
  logic [23:0]      addrReg;
  logic [31:0]      dataReg;
  logic [7:0]       rxByteReg;
  logic [6:0]       rxShift;
  logic [1:0]       misoSync;
  logic [15:0]      divCnt;
  logic [11:0]      bitIdx;
  logic [11:0]      totalBits;
  spfl_host_state_t stateReg;
  logic             sckReg;
  logic             csNReg;
  logic             mosiReg;

  function automatic logic frameBit(input logic [11:0] idx, input logic [7:0] op,
                                    input logic ha, input logic [23:0] ad,
                                    input logic [31:0] dw);
    logic [8:0] k;
    logic [8:0] j;
    logic [7:0] b;
    k = idx[11:3];
    j = ha ? k - 9'h004 : k - 9'h001;
    if (k == 9'h000) begin
      b = op;
    end else if (ha && k == 9'h001) begin
      b = ad[23:16];
    end else if (ha && k == 9'h002) begin
      b = ad[15:8];
    end else if (ha && k == 9'h003) begin
      b = ad[7:0];
    end else begin
      b = dw[{j[1:0], 3'h0} +: 8];
    end
    return b[3'h7 - idx[2:0]];
  endfunction

  wire logic setup    = psel & ~penable;
  wire logic access   = psel & penable & pready;
  wire logic idle     = stateReg == HS_IDLE;
  wire logic halfDone = divCnt == 16'(SCK_HALF - 1);
  wire logic wrCmd    = access & pwrite & ~pslverr & (paddr == `SPFL_REG_CMD);

  assign link.sck  = sckReg;
  assign link.csN  = csNReg;
  assign link.mosi = mosiReg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup && (!(paddr inside {`SPFL_REG_CMD, `SPFL_REG_ADDR, `SPFL_REG_DATA,
                                          `SPFL_REG_STATUS}) ||
                           (pwrite && paddr == `SPFL_REG_CMD && !idle));
      prdata  <= 32'h00000000;
      if (setup && !pwrite) begin
        unique case (paddr)
          `SPFL_REG_CMD:    prdata <= {11'h000, extraReg, countReg, hasAddrReg, opReg};
          `SPFL_REG_ADDR:   prdata <= {8'h00, addrReg};
          `SPFL_REG_DATA:   prdata <= dataReg;
          `SPFL_REG_STATUS: prdata <= {16'h0000, rxByteReg, 7'h00, !idle};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // a program or erase command that software writes must be preceded by a write enable frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opReg      <= 8'h00;
      hasAddrReg <= 1'b0;
      countReg   <= 9'h000;
      extraReg   <= 3'h0;
      addrReg    <= 24'h000000;
      dataReg    <= 32'h00000000;
    end else if (access && pwrite && !pslverr) begin
      unique case (paddr)
        `SPFL_REG_CMD: begin
          opReg      <= pwdata[`SPFL_CMD_OP_LSB +: 8];
          hasAddrReg <= pwdata[`SPFL_CMD_ADDR_BIT];
          countReg   <= pwdata[`SPFL_CMD_CNT_LSB +: 9];
          extraReg   <= pwdata[`SPFL_CMD_EXTRA_LSB +: 3];
        end
        `SPFL_REG_ADDR: addrReg <= pwdata[23:0];
        `SPFL_REG_DATA: dataReg <= pwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      misoSync <= 2'h0;
    end else begin
      misoSync <= {misoSync[0], link.miso};
    end
  end

  // extra bits exist only to exercise refusal of misaligned frames
  always_comb begin
    totalBits = 12'h008 + (hasAddrReg ? 12'h018 : 12'h000) + {countReg, 3'h0} +
                {9'h000, extraReg};
  end

  // miso is sampled at the end of the high phase to absorb both synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg  <= HS_IDLE;
      sckReg    <= 1'b0;
      csNReg    <= 1'b1;
      mosiReg   <= 1'b0;
      divCnt    <= 16'h0000;
      bitIdx    <= 12'h000;
      rxShift   <= 7'h00;
      rxByteReg <= 8'h00;
    end else begin
      unique case (stateReg)
        HS_IDLE: begin
          if (wrCmd) begin
            stateReg <= HS_LOW;
            csNReg   <= 1'b0;
            divCnt   <= 16'h0000;
            bitIdx   <= 12'h000;
          end
        end
        HS_LOW: begin
          mosiReg <= frameBit(bitIdx, opReg, hasAddrReg, addrReg, dataReg);
          divCnt  <= divCnt + 16'h0001;
          if (halfDone) begin
            sckReg   <= 1'b1;
            divCnt   <= 16'h0000;
            stateReg <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          divCnt <= divCnt + 16'h0001;
          if (halfDone) begin
            sckReg  <= 1'b0;
            divCnt  <= 16'h0000;
            rxShift <= {rxShift[5:0], misoSync[1]};
            if (bitIdx[2:0] == 3'h7) begin
              rxByteReg <= {rxShift, misoSync[1]};
            end
            if (bitIdx == totalBits - 12'h001) begin
              stateReg <= HS_TAIL;
            end else begin
              bitIdx   <= bitIdx + 12'h001;
              stateReg <= HS_LOW;
            end
          end
        end
        HS_TAIL: begin
          divCnt <= divCnt + 16'h0001;
          if (halfDone) begin
            divCnt <= 16'h0000;
            if (!csNReg) begin
              csNReg <= 1'b1;
            end else begin
              stateReg <= HS_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule

// *** verilog/spfl_link_if.sv ***
// serial link between host controller and flash device
`timescale 1ns/1ps
interface spfl_link_if;
  logic sck;
  logic csN;
  logic mosi;
  logic miso;
  modport device (input sck, input csN, input mosi, output miso);
  modport host   (output sck, output csN, output mosi, input miso);
endinterface

// *** verilog/spfl_pkg.sv ***
// types shared by both ends of the serial flash link
package spfl_pkg;
  typedef enum logic [7:0] {
    OP_PROG = 8'h02,
    OP_WRDI = 8'h04,
    OP_RDSR = 8'h05,
    OP_WREN = 8'h06,
    OP_SE   = 8'h20,
    OP_CE2  = 8'h60,
    OP_CE1  = 8'hC7,
    OP_BE   = 8'hD8
  } spfl_opcode_t;
  typedef enum logic [1:0] {
    ER_SECTOR = 2'h0,
    ER_BLOCK  = 2'h1,
    ER_CHIP   = 2'h2
  } spfl_erase_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_PROG  = 3'b010,
    ST_ERASE = 3'b100
  } spfl_dev_state_t;
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_LOW  = 4'b0010,
    HS_HIGH = 4'b0100,
    HS_TAIL = 4'b1000
  } spfl_host_state_t;
endpackage

// *** verilog/spfl_regs.svh ***
// offsets, field positions, sizes and timing values
`ifndef SPFL_REGS_SVH
`define SPFL_REGS_SVH
`define SPFL_CLK_NS         25
`define SPFL_PROG_TIME_NS   1000000
`define SPFL_SE_TIME_NS     50000000
`define SPFL_BE_TIME_NS     200000000
`define SPFL_CE_TIME_NS     2000000000
`define SPFL_PAGE_BYTES     256
`define SPFL_MEM_TOP        25'h1000000
`define SPFL_SR_BUSY_BIT    0
`define SPFL_SR_WEL_BIT     1
`define SPFL_SR_BP_LSB      2
`define SPFL_SR_TB_BIT      5
`define SPFL_SR_SEC_BIT     6
`define SPFL_SCK_HALF       4
`define SPFL_REG_CMD        8'h00
`define SPFL_REG_ADDR       8'h04
`define SPFL_REG_DATA       8'h08
`define SPFL_REG_STATUS     8'h0C
`define SPFL_CMD_OP_LSB     0
`define SPFL_CMD_ADDR_BIT   8
`define SPFL_CMD_CNT_LSB    9
`define SPFL_CMD_EXTRA_LSB  18
`define SPFL_ST_ACTIVE_BIT  0
`define SPFL_ST_RX_LSB      8
`endif
